// file: common/serial_status_regs.vh
// Register offsets, field positions, reset values and encodings of the serial status block.
`ifndef SERIAL_STATUS_REGS_VH
`define SERIAL_STATUS_REGS_VH

// ---------------------------------------------------------------
// Register map
// ---------------------------------------------------------------
`define ADDR_W 4
`define ADDR_STATUS 4'h0
`define ADDR_CONTROL 4'h1
`define ADDR_MODE 4'h2
`define ADDR_TX_DATA 4'h3
`define ADDR_RX_DATA 4'h4
`define ADDR_BIT_DIV 4'h5

// ---------------------------------------------------------------
// Status register fields
// ---------------------------------------------------------------
`define ST_TX_EMPTY 7
`define ST_RX_FULL 6
`define ST_OVERRUN 5
`define ST_FRAMING 4
`define ST_PARITY 3
`define ST_TX_DONE 2
`define ST_RX_MP 1
`define ST_TX_MP 0
`define STATUS_RESET 8'h84

// ---------------------------------------------------------------
// Control register fields
// ---------------------------------------------------------------
`define CT_TX_ENABLE 5
`define CT_RX_ENABLE 4
`define CT_STANDBY 0
`define CONTROL_RESET 8'h00

// ---------------------------------------------------------------
// Mode register fields
// ---------------------------------------------------------------
`define MD_SYNC 7
`define MD_PARITY_EN 5
`define MD_PARITY_ODD 4
`define MD_TWO_STOP 3
`define MD_MULTIPROC 2
`define MODE_RESET 8'h00

// ---------------------------------------------------------------
// Bit timing
// ---------------------------------------------------------------
`define BIT_DIV_RESET 8'hFF
`define OVERSAMPLE 4'hF
`define MID_SAMPLE 4'h7
`define DATA_BITS 4'h8

`endif

// file: logic/bit_tick.v
// Divider that makes the sixteen-times oversampling enable pulse.
`timescale 1ns/1ps

module bit_tick (
    // Clock and reset
    input wire clk_sys,
    input wire reset_n,
    // Division setting
    input wire [7:0] divisor,
    // Enable pulse
    output reg tick
);

reg [7:0] count;

always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
        count <= 8'h00;
        tick <= 1'b0;
    end else if (count >= divisor) begin
        count <= 8'h00;
        tick <= 1'b1;
    end else begin
        count <= count + 8'h01;
        tick <= 1'b0;
    end
end

endmodule // bit_tick

// file: logic/serial_unit.v
// Serial unit with status flags, simple transmitter and receiver, and register port.
//
// Added by the designer: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`include "serial_status_regs.vh"

// Contract
// - Good character sets rx_full_flag
// - rx_full_flag clears on reset, standby, read-then-write0
// - Errors and receive disable keep buffer, flag
// - Character while full sets overrun, discards it
// - Overrun stops reception; in sync mode, transmit too
// - Error flags clear by reset, standby, read-write0
// - Stop bit zero sets framing outside sync mode; first stop only
// - Framing error stores data, no full flag
// - Parity mismatch sets parity_flag
// - Parity error stores data, no full flag
// - tx_done sets on reset, standby, disable, end
// - tx_done clears with tx_empty read-write0
// - tx_done is read-only
// - Multiprocessor bit captured, read-only
// - Receive disable keeps rx_multiproc_flag
// - tx_multiproc_flag sent as multiprocessor bit
// - Status resets to 84 hex
// - Writing one sets no flag except tx_multiproc_flag
// - tx_empty sets on reset, standby, disable, load
module serial_unit (
    // Clock and reset
    input wire clk_sys,
    input wire reset_n,
    // Register port
    input wire [`ADDR_W-1:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_write,
    input wire reg_read,
    output reg [7:0] reg_rdata,
    // Serial line
    input wire rx_pin,
    output reg tx_pin
);

// ---------------------------------------------------------------
// Registers
// ---------------------------------------------------------------
reg [7:0] control_register;
reg [7:0] mode_register;
reg [7:0] bit_div;
reg [7:0] tx_buffer;
reg [7:0] rx_buffer;
reg tx_empty_flag;
reg rx_full_flag;
reg overrun_flag;
reg framing_flag;
reg parity_flag;
reg tx_done_flag;
reg rx_multiproc_flag;
reg tx_multiproc_flag;
// Armed bits remember that a flag was read as one.
reg [7:3] armed;

localparam [7:0] STATUS_INIT = `STATUS_RESET;
wire tick;
wire standby = control_register[`CT_STANDBY];
wire rx_enable_bit = control_register[`CT_RX_ENABLE];
wire tx_enable_bit = control_register[`CT_TX_ENABLE];
wire sync_mode = mode_register[`MD_SYNC];
wire mp_mode = mode_register[`MD_MULTIPROC] & ~sync_mode;
wire parity_on = mode_register[`MD_PARITY_EN] & ~sync_mode & ~mp_mode;
wire any_error = overrun_flag | framing_flag | parity_flag;
wire wr_status = reg_write && (reg_addr == `ADDR_STATUS);
wire rd_status = reg_read && (reg_addr == `ADDR_STATUS);
wire [7:0] status_value = {tx_empty_flag, rx_full_flag, overrun_flag, framing_flag,
                           parity_flag, tx_done_flag, rx_multiproc_flag, tx_multiproc_flag};

// A clear takes effect only when armed and the written bit is zero.
function clear_hit;
    input arm;
    input wbit;
    input wr;
    begin
        clear_hit = wr & arm & ~wbit;
    end
endfunction

bit_tick u_bit_tick (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .divisor(bit_div),
    .tick(tick)
);

// ---------------------------------------------------------------
// Input synchroniser
// ---------------------------------------------------------------
reg rx_meta;
reg rx_sync;
always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
        rx_meta <= 1'b1;
        rx_sync <= 1'b1;
    end else begin
        rx_meta <= rx_pin;
        rx_sync <= rx_meta;
    end
end

// ---------------------------------------------------------------
// Receiver
// ---------------------------------------------------------------
localparam RX_IDLE = 2'h0;
localparam RX_START = 2'h1;
localparam RX_BITS = 2'h2;
localparam RX_STOP = 2'h3;

reg [1:0] rx_state;
reg [3:0] rx_phase;
reg [3:0] rx_count;
reg [9:0] rx_shift_reg;
reg rx_done;
reg [9:0] rx_word;
reg rx_stop_bad;

// Number of data bits plus parity or multiprocessor bit in this frame.
wire [3:0] rx_len = (parity_on || mp_mode) ? `DATA_BITS + 4'h1 : `DATA_BITS;
// Errors block a new frame from starting at all.
wire rx_go = rx_enable_bit && !any_error && !standby;

always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
        rx_state <= RX_IDLE;
        rx_phase <= 4'h0;
        rx_count <= 4'h0;
        rx_shift_reg <= 10'h000;
        rx_done <= 1'b0;
        rx_word <= 10'h000;
        rx_stop_bad <= 1'b0;
    end else begin
        rx_done <= 1'b0;
        if (!rx_go) begin
            rx_state <= RX_IDLE;
        end else if (tick) begin
            rx_phase <= rx_phase + 4'h1;
            case (rx_state)
                RX_IDLE: begin
                    rx_phase <= 4'h0;
                    if (!rx_sync) begin
                        rx_state <= RX_START;
                    end
                end
                RX_START: begin
                    if (rx_phase == `MID_SAMPLE) begin
                        rx_phase <= 4'h0;
                        rx_count <= 4'h0;
                        rx_state <= rx_sync ? RX_IDLE : RX_BITS;
                    end
                end
                RX_BITS: begin
                    if (rx_phase == `OVERSAMPLE) begin
                        rx_shift_reg <= {rx_sync, rx_shift_reg[9:1]};
                        rx_count <= rx_count + 4'h1;
                        if (rx_count + 4'h1 == rx_len) begin
                            rx_state <= RX_STOP;
                        end
                    end
                end
                RX_STOP: begin
                    // Only the first stop bit is sampled; a second is just idle line.
                    if (rx_phase == `OVERSAMPLE) begin
                        rx_state <= RX_IDLE;
                        rx_done <= 1'b1;
                        rx_stop_bad <= ~rx_sync & ~sync_mode;
                        rx_word <= (rx_len == `DATA_BITS) ? {2'h0, rx_shift_reg[9:2]}
                                                          : {1'b0, rx_shift_reg[9:1]};
                    end
                end
                default: begin
                    rx_state <= RX_IDLE;
                end
            endcase
        end
    end
end

wire rx_parity_bad = parity_on &&
    ((^rx_word[8:0]) != mode_register[`MD_PARITY_ODD]);

// ---------------------------------------------------------------
// Transmitter
// ---------------------------------------------------------------
localparam TX_IDLE = 2'h0;
localparam TX_SEND = 2'h1;

reg [1:0] tx_state;
reg [3:0] tx_phase;
reg [3:0] tx_count;
reg [10:0] tx_shift_reg;
reg [3:0] tx_len;
wire tx_blocked = sync_mode && any_error;
wire tx_load = tx_enable_bit && !standby && !tx_empty_flag && !tx_blocked &&
               tx_state == TX_IDLE && tick;
wire tx_last = tx_state == TX_SEND && tick && tx_phase == `OVERSAMPLE &&
               tx_count == tx_len;

always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
        tx_state <= TX_IDLE;
        tx_phase <= 4'h0;
        tx_count <= 4'h0;
        tx_shift_reg <= 11'h7FF;
        tx_len <= 4'h0;
        tx_pin <= 1'b1;
    end else if (!tx_enable_bit || standby) begin
        tx_state <= TX_IDLE;
        tx_pin <= 1'b1;
    end else if (tx_load) begin
        tx_state <= TX_SEND;
        tx_phase <= 4'h0;
        tx_count <= 4'h0;
        if (mp_mode) begin
            tx_shift_reg <= {1'b1, tx_multiproc_flag, tx_buffer, 1'b0};
            tx_len <= `DATA_BITS + 4'h2;
        end else if (parity_on) begin
            tx_shift_reg <= {1'b1, (^tx_buffer) ^ mode_register[`MD_PARITY_ODD],
                             tx_buffer, 1'b0};
            tx_len <= `DATA_BITS + 4'h2;
        end else begin
            tx_shift_reg <= {2'h3, tx_buffer, 1'b0};
            tx_len <= `DATA_BITS + 4'h1;
        end
    end else if (tx_state == TX_SEND && tick) begin
        tx_phase <= tx_phase + 4'h1;
        if (tx_phase == 4'h0) begin
            tx_pin <= tx_shift_reg[0];
        end
        if (tx_phase == `OVERSAMPLE) begin
            tx_shift_reg <= {1'b1, tx_shift_reg[10:1]};
            tx_count <= tx_count + 4'h1;
            if (tx_last) begin
                tx_state <= TX_IDLE;
                tx_pin <= 1'b1;
            end
        end
    end
end

// ---------------------------------------------------------------
// Status flags
// ---------------------------------------------------------------
always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
        tx_empty_flag <= STATUS_INIT[`ST_TX_EMPTY];
        rx_full_flag <= 1'b0;
        overrun_flag <= 1'b0;
        framing_flag <= 1'b0;
        parity_flag <= 1'b0;
        tx_done_flag <= STATUS_INIT[`ST_TX_DONE];
        rx_multiproc_flag <= 1'b0;
        tx_multiproc_flag <= 1'b0;
        armed <= 5'h00;
        rx_buffer <= 8'h00;
    end else if (standby) begin
        tx_empty_flag <= 1'b1;
        rx_full_flag <= 1'b0;
        overrun_flag <= 1'b0;
        framing_flag <= 1'b0;
        parity_flag <= 1'b0;
        tx_done_flag <= 1'b1;
        rx_multiproc_flag <= 1'b0;
        tx_multiproc_flag <= 1'b0;
        armed <= 5'h00;
    end else begin
        // Arm on a read that sees one; disarm on the write that clears it.
        if (rd_status) begin
            armed <= armed | status_value[7:3];
        end
        // Software clears first; hardware sets below win in the same cycle.
        if (clear_hit(armed[`ST_TX_EMPTY], reg_wdata[`ST_TX_EMPTY], wr_status)) begin
            tx_empty_flag <= 1'b0;
            tx_done_flag <= 1'b0;
            armed[`ST_TX_EMPTY] <= 1'b0;
        end
        if (clear_hit(armed[`ST_RX_FULL], reg_wdata[`ST_RX_FULL], wr_status)) begin
            rx_full_flag <= 1'b0;
            armed[`ST_RX_FULL] <= 1'b0;
        end
        if (clear_hit(armed[`ST_OVERRUN], reg_wdata[`ST_OVERRUN], wr_status)) begin
            overrun_flag <= 1'b0;
            armed[`ST_OVERRUN] <= 1'b0;
        end
        if (clear_hit(armed[`ST_FRAMING], reg_wdata[`ST_FRAMING], wr_status)) begin
            framing_flag <= 1'b0;
            armed[`ST_FRAMING] <= 1'b0;
        end
        if (clear_hit(armed[`ST_PARITY], reg_wdata[`ST_PARITY], wr_status)) begin
            parity_flag <= 1'b0;
            armed[`ST_PARITY] <= 1'b0;
        end
        // Writes of one clear nothing; tx_done and rx_multiproc have no write path; tx_multiproc_flag takes the written bit.
        if (wr_status) begin
            tx_multiproc_flag <= reg_wdata[`ST_TX_MP];
        end
        // Receive completion.
        if (rx_done) begin
            if (mp_mode) begin
                rx_multiproc_flag <= rx_word[8];
            end
            if (rx_full_flag) begin
                overrun_flag <= 1'b1;
            end else if (rx_stop_bad || rx_parity_bad) begin
                rx_buffer <= rx_word[7:0];
                framing_flag <= rx_stop_bad | framing_flag;
                parity_flag <= rx_parity_bad | parity_flag;
            end else begin
                rx_buffer <= rx_word[7:0];
                rx_full_flag <= 1'b1;
            end
        end
        // Transmit side.
        if (!tx_enable_bit) begin
            tx_empty_flag <= 1'b1;
            tx_done_flag <= 1'b1;
        end else begin
            if (tx_load) begin
                tx_empty_flag <= 1'b1;
                tx_done_flag <= 1'b0;
            end
            if (tx_last && tx_empty_flag) begin
                tx_done_flag <= 1'b1;
            end
        end
    end
end

// ---------------------------------------------------------------
// Register port
// ---------------------------------------------------------------
always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
        control_register <= `CONTROL_RESET;
        mode_register <= `MODE_RESET;
        bit_div <= `BIT_DIV_RESET;
        tx_buffer <= 8'h00;
        reg_rdata <= 8'h00;
    end else begin
        if (reg_write) begin
            case (reg_addr)
                `ADDR_CONTROL: control_register <= reg_wdata;
                `ADDR_MODE: mode_register <= reg_wdata;
                `ADDR_BIT_DIV: bit_div <= reg_wdata;
                `ADDR_TX_DATA: tx_buffer <= reg_wdata;
                default: begin
                end
            endcase
        end
        reg_rdata <= 8'h00;
        if (reg_read) begin
            case (reg_addr)
                `ADDR_STATUS: reg_rdata <= status_value;
                `ADDR_CONTROL: reg_rdata <= control_register;
                `ADDR_MODE: reg_rdata <= mode_register;
                `ADDR_BIT_DIV: reg_rdata <= bit_div;
                `ADDR_TX_DATA: reg_rdata <= tx_buffer;
                `ADDR_RX_DATA: reg_rdata <= rx_buffer;
                default: reg_rdata <= 8'h00;
            endcase
        end
    end
end

endmodule // serial_unit

// file: verification/remote_station.sv
// Remote station model that frames bytes onto the unit's line and captures its output.
`timescale 1ns/1ps

module remote_station #(
    parameter BIT_CLK = 16
) (
    // Clock
    input wire clk_sys,
    // Serial lines
    input wire tx_pin,
    output reg rx_pin
);
    reg [7:0] got_byte = 8'h00;
    reg got_extra = 1'b0;
    integer i;

    initial rx_pin = 1'b1;

    // Start bit, data LSB first, optional extra bit, stop bit; a spare high bit closes short frames.
    task send(input [7:0] d, input has_extra, input extra, input stop_bit);
        reg [10:0] f;
        integer k;
        begin
            f = has_extra ? {stop_bit, extra, d, 1'b0} : {1'b1, stop_bit, d, 1'b0};
            for (k = 0; k < 11; k = k + 1) begin
                @(posedge clk_sys);
                rx_pin <= f[k];
                repeat (BIT_CLK - 1) @(posedge clk_sys);
            end
        end
    endtask

    // Sample mid-bit; the ninth bit is the parity bit, the multiprocessor bit or the stop bit.
    always begin
        @(negedge tx_pin);
        repeat (BIT_CLK / 2) @(posedge clk_sys);
        for (i = 0; i < 9; i = i + 1) begin
            repeat (BIT_CLK) @(posedge clk_sys);
            if (i < 8) got_byte[i] = tx_pin;
            else got_extra = tx_pin;
        end
    end
endmodule // remote_station

// file: verification/serial_unit_chk.sv
// Concurrent checks on the serial unit's register port and line.
`timescale 1ns/1ps
`include "serial_status_regs.vh"

module serial_unit_chk (
    // Clock and reset
    input wire clk_sys,
    input wire reset_n,
    // Register port
    input wire [`ADDR_W-1:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_write,
    input wire reg_read,
    input wire [7:0] reg_rdata,
    // Serial line
    input wire rx_pin,
    input wire tx_pin
);
    // Line activity may set flags at any time, so flag checks wait for a long quiet line.
    reg fresh;
    reg [8:0] quiet_cnt;
    wire quiet = quiet_cnt >= 9'h190;

    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            fresh <= 1'b1;
            quiet_cnt <= 9'h000;
        end else begin
            if (reg_write || !rx_pin) fresh <= 1'b0;
            if (!(rx_pin && tx_pin)) quiet_cnt <= 9'h000;
            else if (quiet_cnt != 9'h1FF) quiet_cnt <= quiet_cnt + 9'h001;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    sequence st_rd; reg_read && reg_addr == `ADDR_STATUS; endsequence
    sequence st_wr; reg_write && reg_addr == `ADDR_STATUS; endsequence
    sequence q_cycle; quiet && reg_read && reg_addr == `ADDR_STATUS ##1 st_wr ##1 st_rd; endsequence
    sequence q_keep;
        quiet && reg_read && reg_addr == `ADDR_STATUS
        ##1 reg_write && reg_addr == `ADDR_STATUS && reg_wdata[7] ##1 st_rd;
    endsequence
    sequence q_tx_done_flag;
        quiet && reg_read && reg_addr == `ADDR_STATUS
        ##1 reg_write && reg_addr == `ADDR_STATUS && reg_rdata[7] && !reg_wdata[7] ##1 st_rd;
    endsequence

    a_rdata_idle: assert property (!reg_read |=> reg_rdata == 8'h00)
        else $error("read data not zero outside read cycle");
    a_reset_value: assert property (
        fresh && reg_read && reg_addr == `ADDR_STATUS |=> reg_rdata == `STATUS_RESET)
        else $error("status not at reset value");
    a_line_idle: assert property (fresh |-> tx_pin)
        else $error("line active without any write");
    a_write_no_set: assert property (
        q_cycle |=> (reg_rdata[6:3] & ~$past(reg_rdata[6:3], 2)) == 4'h0)
        else $error("status write set a flag");
    a_clear_after_read: assert property (
        q_cycle |=> (reg_rdata[6:3] & $past(reg_rdata[6:3], 2) & ~$past(reg_wdata[6:3], 2)) == 4'h0)
        else $error("flag read as one not cleared by zero write");
    a_flags_readonly: assert property (
        q_keep |=> reg_rdata[2:1] == $past(reg_rdata[2:1], 2))
        else $error("read-only status bits changed by write");
    a_tx_done_flag_clear: assert property (q_tx_done_flag |=> !reg_rdata[2])
        else $error("transmit end not cleared with transmit empty");
    a_mp_write: assert property (st_wr ##1 st_rd |=> reg_rdata[0] == $past(reg_wdata[0], 2))
        else $error("transmit multiprocessor bit not written");
endmodule // serial_unit_chk

bind serial_unit serial_unit_chk u_chk (
    .clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .rx_pin(rx_pin), .tx_pin(tx_pin)
);

// file: verification/serial_unit_tb_top.sv
// Self-checking testbench of the serial unit against a remote station.
`timescale 1ns/1ps
`include "serial_status_regs.vh"

module serial_unit_tb_top;
    localparam [3:0] AS = `ADDR_STATUS;
    localparam [3:0] AR = `ADDR_RX_DATA;
    reg clk_sys = 1'b0;
    reg reset_n = 1'b0;
    reg [3:0] reg_addr = 4'h0;
    reg [7:0] reg_wdata = 8'h00;
    reg reg_write = 1'b0;
    reg reg_read = 1'b0;
    wire [7:0] reg_rdata;
    wire rx_pin;
    wire tx_pin;
    integer n_mismatch = 0;
    integer total_checks = 0;
    integer i;
    reg [7:0] s1;
    reg [7:0] s2;
    reg [11:0] rows [0:4];

    always #12.5 clk_sys = ~clk_sys;

    serial_unit u_dut (
        .clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .rx_pin(rx_pin), .tx_pin(tx_pin)
    );
    remote_station u_peer (.clk_sys(clk_sys), .tx_pin(tx_pin), .rx_pin(rx_pin));

    task stop_test;
        begin
            if (n_mismatch == 0 && total_checks > 0) $display("STATUS OK");
            else $display("STATUS NOT OK");
            $finish;
        end
    endtask

    task chk(input [7:0] got, input [7:0] exp);
        begin
            total_checks = total_checks + 1;
            if (got !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("[ERR] %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask

    task idle(input integer n);
        repeat (n) @(posedge clk_sys);
    endtask

    task wr(input [3:0] a, input [7:0] d);
        begin
            @(posedge clk_sys);
            reg_write <= 1'b1;
            reg_addr <= a;
            reg_wdata <= d;
            @(posedge clk_sys);
            reg_write <= 1'b0;
        end
    endtask

    task rd(input [3:0] a, output [7:0] d);
        begin
            @(posedge clk_sys);
            reg_read <= 1'b1;
            reg_addr <= a;
            @(posedge clk_sys);
            reg_read <= 1'b0;
            @(negedge clk_sys);
            d = reg_rdata;
        end
    endtask

    // Status read, write, read back to back, as software clears a flag it has seen.
    task rwr(input [7:0] w);
        begin
            @(posedge clk_sys);
            reg_read <= 1'b1;
            reg_addr <= AS;
            @(posedge clk_sys);
            reg_read <= 1'b0;
            reg_write <= 1'b1;
            reg_wdata <= w;
            @(negedge clk_sys);
            s1 = reg_rdata;
            @(posedge clk_sys);
            reg_write <= 1'b0;
            reg_read <= 1'b1;
            @(posedge clk_sys);
            reg_read <= 1'b0;
            @(negedge clk_sys);
            s2 = reg_rdata;
        end
    endtask

    initial begin
        idle(100000);
        n_mismatch = n_mismatch + 1;
        stop_test;
    end

    initial begin
        rows[0] = {AS, `STATUS_RESET};
        rows[1] = {`ADDR_CONTROL, `CONTROL_RESET};
        rows[2] = {`ADDR_MODE, `MODE_RESET};
        rows[3] = {`ADDR_BIT_DIV, `BIT_DIV_RESET};
        rows[4] = {4'hF, 8'h00};
        idle(20);
        reset_n <= 1'b1;
        for (i = 0; i < 5; i = i + 1) begin
            rd(rows[i][11:8], s1);
            chk(s1, rows[i][7:0]);
        end
        wr(AS, 8'hFA);
        wr(4'hF, 8'h5A);
        rd(AS, s1);
        chk(s1, 8'h84);
        rd(4'hF, s1);
        chk(s1, 8'h00);
        wr(`ADDR_BIT_DIV, 8'h00);
        wr(`ADDR_CONTROL, 8'h30);
        u_peer.send(8'h5A, 1'b0, 1'b0, 1'b1);
        idle(40);
        wr(AS, 8'h84);
        rd(AR, s1);
        chk(s1, 8'h5A);
        rd(AS, s1);
        chk(s1 & 8'h78, 8'h40);
        u_peer.send(8'hC3, 1'b0, 1'b0, 1'b1);
        idle(40);
        u_peer.send(8'h11, 1'b0, 1'b0, 1'b1);
        idle(40);
        rd(AS, s1);
        chk(s1 & 8'h78, 8'h60);
        rd(AR, s1);
        chk(s1, 8'h5A);
        idle(400);
        rwr(8'h84);
        chk(s2 & 8'h78, 8'h00);
        u_peer.send(8'h22, 1'b0, 1'b0, 1'b1);
        idle(40);
        rd(AR, s1);
        chk(s1, 8'h22);
        rwr(8'h84);
        u_peer.send(8'h3C, 1'b0, 1'b0, 1'b0);
        idle(40);
        rd(AS, s1);
        chk(s1 & 8'h78, 8'h10);
        wr(`ADDR_CONTROL, 8'h20);
        rd(AS, s1);
        chk(s1 & 8'h78, 8'h10);
        wr(`ADDR_CONTROL, 8'h30);
        u_peer.send(8'h44, 1'b0, 1'b0, 1'b1);
        idle(40);
        rd(AR, s1);
        chk(s1, 8'h3C);
        rwr(8'h84);
        wr(`ADDR_MODE, 8'h20);
        u_peer.send(8'h01, 1'b1, 1'b0, 1'b1);
        idle(40);
        rd(AS, s1);
        chk(s1 & 8'h78, 8'h08);
        rd(AR, s1);
        chk(s1, 8'h01);
        rwr(8'h84);
        wr(`ADDR_MODE, 8'h30);
        u_peer.send(8'h01, 1'b1, 1'b0, 1'b1);
        idle(40);
        rd(AS, s1);
        chk(s1 & 8'h78, 8'h40);
        rwr(8'h84);
        wr(`ADDR_MODE, 8'h04);
        u_peer.send(8'hA5, 1'b1, 1'b1, 1'b1);
        idle(40);
        rd(AS, s1);
        wr(AS, 8'hFF);
        rd(AS, s1);
        chk(s1 & 8'h07, 8'h07);
        wr(`ADDR_TX_DATA, 8'h96);
        idle(400);
        rwr(8'h01);
        chk(s2 & 8'h05, 8'h01);
        idle(250);
        chk(u_peer.got_byte, 8'h96);
        chk({7'h00, u_peer.got_extra}, 8'h01);
        rd(AS, s1);
        chk(s1 & 8'h84, 8'h84);
        wr(`ADDR_CONTROL, 8'h20);
        rd(AS, s1);
        chk(s1 & 8'h02, 8'h02);
        wr(`ADDR_CONTROL, 8'h01);
        rd(AS, s1);
        chk(s1, 8'h84);
        stop_test;
    end
endmodule // serial_unit_tb_top
